// [rsc_map.svh]
// offsets, field positions, reset values and codes of the run/step selector
// Operation
// - run active: step index from three select bits
// - function codes 5,6,7 make step bits
// - step 0 base, 1-7 stored step frequencies
// - keypad mode: run key starts, stop decelerates
// - keypad mode: direction bit picks forward/reverse
// - remote keypad present masks built-in keypad
// - terminal mode: codes 0/1 forward/reverse run
// - terminal mode: both equal means stop
// - mode 2: forward runs, reverse picks direction
// - mode 3: serial link gives run command
// - bipolar source: negative input inverts direction
// - polarity flip while running: stop, then reverse
// - inhibit selector blocks forward or reverse
// - power-up autostart for terminal modes only
// - fault-clear autostart for terminal modes only
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH

// register byte offsets
`define RSC_OFF_CTRL 8'h00
`define RSC_OFF_TFUNC_LO 8'h04
`define RSC_OFF_TFUNC_HI 8'h08
`define RSC_OFF_BASE 8'h0C
`define RSC_OFF_COMM 8'h10
`define RSC_OFF_SERIAL 8'h14
`define RSC_OFF_STATUS 8'h18
`define RSC_OFF_STEP1 8'h20
`define RSC_OFF_STEP7 8'h38

// control register fields
`define RSC_CTRL_RUNSRC 1:0
`define RSC_CTRL_FSRC 7:4
`define RSC_CTRL_INHIBIT 9:8
`define RSC_CTRL_KPDIR 12
`define RSC_CTRL_PWRAUTO 16
`define RSC_CTRL_FLTAUTO 17
`define RSC_CTRL_RST 32'h0000_0001

// comm register fields and resets
`define RSC_COMM_PROTO 0
`define RSC_COMM_STATION 15:8
`define RSC_COMM_BAUD 18:16
`define RSC_COMM_RST 32'h0003_0100
`define RSC_STATION_MIN 8'h01
`define RSC_STATION_MAX 8'hFA

// terminal function fields, reset puts terminal n on code n-1
`define RSC_TFUNC_W 5
`define RSC_TFUNC_LO_RST 32'h0302_0100
`define RSC_TFUNC_HI_RST 32'h0706_0504
`define RSC_FN_FWD 5'h00
`define RSC_FN_REV 5'h01
`define RSC_FN_STEP_LO 5'h05
`define RSC_FN_STEP_MID 5'h06
`define RSC_FN_STEP_HI 5'h07

// frequency reset values in 0.01 Hz
`define RSC_STEP_RST {16'h05DC, 16'h07D0, 16'h09C4, 16'h0BB8, 16'h0BB8, 16'h07D0, 16'h03E8}
`define RSC_BASE_RST 16'h0000

// source and inhibit codes
`define RSC_SRC_KEYPAD 2'h0
`define RSC_SRC_TERM 2'h1
`define RSC_SRC_TERMDIR 2'h2
`define RSC_SRC_SERIAL 2'h3
`define RSC_FSRC_KEYPAD 4'h0
`define RSC_FSRC_BIPOLAR 4'h2
`define RSC_INH_FWD 2'h1
`define RSC_INH_REV 2'h2

`endif

// [rsc_partner.sv]
// operator terminals, keypads, fault source and motor ramp model
`timescale 1ns/1ps
module rsc_partner #(
  parameter int STOP_CYC = 6
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic run_cmd,
  output logic [7:0] term_in,
  output logic run_key,
  output logic stop_reset_key,
  output logic remote_keypad_present,
  output logic remote_run_key,
  output logic remote_stop_key,
  output logic signed [11:0] bipolar_voltage_input,
  output logic [15:0] analog_freq_ref,
  output logic fault_active,
  output logic fault_clear,
  output logic motor_stopped
);
  int cnt;
  // ramp: a dropped run command coasts for a while, so reversal must wait
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) cnt <= STOP_CYC;
    else if (run_cmd) cnt <= 0;
    else if (cnt < STOP_CYC) cnt <= cnt + 1;
  end
  assign motor_stopped = (cnt == STOP_CYC);
  assign analog_freq_ref = 16'h0ABC;
  // switches idle open at power-up
  initial begin
    term_in = 8'h00;
    {remote_keypad_present, remote_run_key, remote_stop_key, run_key, stop_reset_key} = 5'h00;
    bipolar_voltage_input = 12'h400;
    fault_active = 1'b0;
    fault_clear = 1'b0;
  end
  // levels change just after an edge; keys order {rem, rem_run, rem_stop, run, stop}
  task automatic drive(input logic [7:0] t, input logic [4:0] k, input logic neg,
                       input logic flt);
    @(posedge clk_sys);
    term_in <= t;
    {remote_keypad_present, remote_run_key, remote_stop_key, run_key, stop_reset_key} <= k;
    bipolar_voltage_input <= neg ? 12'hC00 : 12'h400;
    fault_active <= flt;
  endtask
  // fault goes away and clear pulses for one cycle in the same edge
  task automatic end_fault();
    @(posedge clk_sys);
    fault_active <= 1'b0;
    fault_clear <= 1'b1;
    @(posedge clk_sys);
    fault_clear <= 1'b0;
  endtask
endmodule

// [rsc_pkg.sv]
// types shared by the run/step selector
package rsc_pkg;
  typedef enum logic [1:0] {st_idle, st_run, st_reversing} rsc_state_t;
  typedef logic [15:0] rsc_freq_t;
  typedef logic [2:0] rsc_step_t;
endpackage

// [rsc_step_mux.sv]
// step index to frequency reference selection
`timescale 1ns/1ps
module rsc_step_mux #(
  parameter int W = 16
) (
  input wire logic [2:0] idx,
  input wire logic [W-1:0] base_freq,
  input wire logic [7*W-1:0] steps,
  output logic [W-1:0] freq
);
  import rsc_pkg::*;

  // index 0 parks the slot at zero so the unused select stays in range
  wire logic [2:0] slot = (idx == 3'h0) ? 3'h0 : idx - 3'h1;

  // index 0 is base reference, others stored steps
  assign freq = (idx == 3'h0) ? base_freq : steps[slot*W +: W];
endmodule

// [rsc_term_decode.sv]
// multi-function terminal decode into run and step-select signals
`timescale 1ns/1ps
`include "rsc_map.svh"
module rsc_term_decode #(
  parameter int N = 8
) (
  input wire logic [N-1:0] term_in,
  input wire logic [N*`RSC_TFUNC_W-1:0] funcs,
  output logic fwd,
  output logic rev,
  output rsc_pkg::rsc_step_t step_bits
);
  import rsc_pkg::*;

  function automatic logic is_code(input logic [`RSC_TFUNC_W-1:0] f,
                                   input logic [`RSC_TFUNC_W-1:0] code);
    is_code = (f == code);
  endfunction

  logic [N-1:0] hit_fwd;
  logic [N-1:0] hit_rev;
  logic [N-1:0] hit_lo;
  logic [N-1:0] hit_mid;
  logic [N-1:0] hit_hi;

  // per-terminal function match; several terminals on one code simply OR
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_term
      wire logic [`RSC_TFUNC_W-1:0] f = funcs[i*`RSC_TFUNC_W +: `RSC_TFUNC_W];
      assign hit_fwd[i] = term_in[i] & is_code(f, `RSC_FN_FWD);
      assign hit_rev[i] = term_in[i] & is_code(f, `RSC_FN_REV);
      assign hit_lo[i] = term_in[i] & is_code(f, `RSC_FN_STEP_LO);
      assign hit_mid[i] = term_in[i] & is_code(f, `RSC_FN_STEP_MID);
      assign hit_hi[i] = term_in[i] & is_code(f, `RSC_FN_STEP_HI);
    end
  endgenerate

  // high bit c, low bit a
  assign fwd = |hit_fwd;
  assign rev = |hit_rev;
  assign step_bits = {|hit_hi, |hit_mid, |hit_lo};
endmodule

// [rsc_top.sv]
// run command, direction and multi-step reference selector with wishbone registers
//
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "rsc_map.svh"
module rsc_top #(
  parameter logic PWR_AUTOSTART_INIT = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] term_in,
  input wire logic run_key,
  input wire logic stop_reset_key,
  input wire logic remote_keypad_present,
  input wire logic remote_run_key,
  input wire logic remote_stop_key,
  input wire logic signed [11:0] bipolar_voltage_input,
  input wire logic [15:0] analog_freq_ref,
  input wire logic fault_active,
  input wire logic fault_clear,
  input wire logic motor_stopped,
  output logic run_cmd,
  output logic dir_reverse,
  output rsc_pkg::rsc_step_t step_index,
  output rsc_pkg::rsc_freq_t freq_target
);
  import rsc_pkg::*;

  // byte-lane merge used by every writable register except the serial command
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] sel);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        merge[b*8 +: 8] = val[b*8 +: 8];
      end
    end
  endfunction

  logic [31:0] ctrl;
  logic [31:0] tfunc_lo;
  logic [31:0] tfunc_hi;
  rsc_freq_t base_freq;
  logic [31:0] comm;
  logic [1:0] serial_cmd;
  logic [7*16-1:0] step_freq;
  rsc_state_t state;
  logic keypad_run;
  logic term_wait;
  logic first_cycle;

  // bus decode; write lands on the edge the master sees ack
  wire logic req = wb_cyc_i & wb_stb_i;
  wire logic wr = req & wb_we_i & wb_ack_o;
  wire logic [7:0] adr = {wb_adr_i[7:2], 2'b00};
  wire logic hit_step = (adr >= `RSC_OFF_STEP1) && (adr <= `RSC_OFF_STEP7);
  wire logic [2:0] step_slot = 3'(adr[4:2]);
  wire logic [31:0] comm_new = merge(comm, wb_dat_i, wb_sel_i);
  wire logic station_ok = (comm_new[`RSC_COMM_STATION] >= `RSC_STATION_MIN)
                        && (comm_new[`RSC_COMM_STATION] <= `RSC_STATION_MAX);

  // configuration fields
  wire logic [1:0] run_source_sel = ctrl[`RSC_CTRL_RUNSRC];
  wire logic [3:0] freq_source_sel = ctrl[`RSC_CTRL_FSRC];
  wire logic [1:0] direction_inhibit_sel = ctrl[`RSC_CTRL_INHIBIT];
  wire logic keypad_direction_sel = ctrl[`RSC_CTRL_KPDIR];
  wire logic power_up_autostart = ctrl[`RSC_CTRL_PWRAUTO];
  wire logic fault_clear_autostart = ctrl[`RSC_CTRL_FLTAUTO];

  // terminal decode
  logic fwd_t;
  logic rev_t;
  rsc_step_t step_bits;
  rsc_term_decode #(.N(8)) u_dec (
    .term_in(term_in),
    .funcs({tfunc_hi[28:24], tfunc_hi[20:16], tfunc_hi[12:8], tfunc_hi[4:0],
            tfunc_lo[28:24], tfunc_lo[20:16], tfunc_lo[12:8], tfunc_lo[4:0]}),
    .fwd(fwd_t),
    .rev(rev_t),
    .step_bits(step_bits)
  );

  // remote keypad masks the built-in keys
  wire logic kp_run = remote_keypad_present ? remote_run_key : run_key;
  wire logic kp_stop = remote_keypad_present ? remote_stop_key : stop_reset_key;

  // source selection of raw run request and direction
  wire logic mode_kp = run_source_sel == `RSC_SRC_KEYPAD;
  wire logic mode_t1 = run_source_sel == `RSC_SRC_TERM;
  wire logic mode_t2 = run_source_sel == `RSC_SRC_TERMDIR;
  wire logic mode_ser = run_source_sel == `RSC_SRC_SERIAL;
  wire logic term_mode = mode_t1 | mode_t2;
  // equal terminals mean stop; forward runs in mode 2
  wire logic term_req = mode_t1 ? (fwd_t ^ rev_t) : fwd_t;
  // serial link drives forward and reverse bits; equal bits mean stop
  wire logic ser_req = serial_cmd[0] ^ serial_cmd[1];
  wire logic raw_req = mode_kp ? keypad_run : (term_mode ? term_req : ser_req);
  // keypad direction; reverse terminal picks direction
  wire logic raw_rev = mode_kp ? keypad_direction_sel :
                       (term_mode ? rev_t : serial_cmd[1]);
  // negative bipolar input inverts the commanded direction
  wire logic bip_neg = (freq_source_sel == `RSC_FSRC_BIPOLAR) & bipolar_voltage_input[11];
  wire logic want_rev = raw_rev ^ bip_neg;
  wire logic blocked = ((direction_inhibit_sel == `RSC_INH_FWD) & ~want_rev)
                     | ((direction_inhibit_sel == `RSC_INH_REV) & want_rev);
  // a held terminal waits unless autostart applies; the clear
  // cycle itself is held too, since term_wait only arms one edge later
  wire logic term_hold = term_wait | (fault_clear & ~fault_clear_autostart);
  wire logic go = raw_req & ~(term_mode & term_hold) & ~fault_active & ~blocked;

  // step bits only count while a run command is active
  wire rsc_step_t next_step = go ? step_bits : 3'h0;
  wire rsc_freq_t base_sel = (freq_source_sel == `RSC_FSRC_KEYPAD) ? base_freq
                                                                   : analog_freq_ref;
  rsc_freq_t next_freq;
  rsc_step_mux #(.W(16)) u_mux (
    .idx(next_step),
    .base_freq(base_sel),
    .steps(step_freq),
    .freq(next_freq)
  );

  // run state machine; reversal passes through a full stop
  rsc_state_t next_state;
  logic next_dir;
  always_comb begin
    next_state = state;
    next_dir = dir_reverse;
    case (state)
      st_idle: begin
        if (go) begin
          next_state = st_run;
          next_dir = want_rev;
        end
      end
      st_run: begin
        // losing the command decelerates to stop
        if (!go) begin
          next_state = st_idle;
        end else if (want_rev != dir_reverse) begin
          next_state = st_reversing;
        end
      end
      st_reversing: begin
        if (!go) begin
          next_state = st_idle;
        end else if (motor_stopped) begin
          next_state = st_run;
          next_dir = want_rev;
        end
      end
      default: next_state = st_idle;
    endcase
  end

  // read mux; unmapped offsets read zero
  wire logic [31:0] status = {freq_target, 6'h00, 2'(state), 1'b0, step_index,
                              2'b00, dir_reverse, run_cmd};
  wire logic [31:0] rd_data =
    (adr == `RSC_OFF_CTRL) ? ctrl :
    (adr == `RSC_OFF_TFUNC_LO) ? tfunc_lo :
    (adr == `RSC_OFF_TFUNC_HI) ? tfunc_hi :
    (adr == `RSC_OFF_BASE) ? {16'h0000, base_freq} :
    (adr == `RSC_OFF_COMM) ? comm :
    (adr == `RSC_OFF_SERIAL) ? {30'h0, serial_cmd} :
    (adr == `RSC_OFF_STATUS) ? status :
    hit_step ? {16'h0000, step_freq[step_slot*16 +: 16]} : 32'h0000_0000;

  // wishbone handshake: ack one cycle after strobe, dropped the next
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= rd_data;
    end
  end

  // configuration registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `RSC_CTRL_RST | {15'h0, PWR_AUTOSTART_INIT, 16'h0};
      tfunc_lo <= `RSC_TFUNC_LO_RST;
      tfunc_hi <= `RSC_TFUNC_HI_RST;
      base_freq <= `RSC_BASE_RST;
      comm <= `RSC_COMM_RST;
      serial_cmd <= 2'b00;
      step_freq <= `RSC_STEP_RST;
    end else if (wr) begin
      if (adr == `RSC_OFF_CTRL) begin
        ctrl <= merge(ctrl, wb_dat_i, wb_sel_i) & 32'h0003_13F3;
      end
      if (adr == `RSC_OFF_TFUNC_LO) begin
        tfunc_lo <= merge(tfunc_lo, wb_dat_i, wb_sel_i) & 32'h1F1F_1F1F;
      end
      if (adr == `RSC_OFF_TFUNC_HI) begin
        tfunc_hi <= merge(tfunc_hi, wb_dat_i, wb_sel_i) & 32'h1F1F_1F1F;
      end
      if (adr == `RSC_OFF_BASE) begin
        base_freq <= 16'(merge({16'h0, base_freq}, wb_dat_i, wb_sel_i));
      end
      // station number outside 1..250 is refused
      if (adr == `RSC_OFF_COMM && station_ok) begin
        comm <= comm_new & 32'h0007_FF01;
      end
      if (adr == `RSC_OFF_SERIAL && wb_sel_i[0]) begin
        serial_cmd <= wb_dat_i[1:0];
      end
      if (hit_step) begin
        step_freq[step_slot*16 +: 16] <=
          16'(merge({16'h0, step_freq[step_slot*16 +: 16]}, wb_dat_i, wb_sel_i));
      end
    end
  end

  // keypad run latch; stop key wins for safety
  wire logic next_kp_run = (mode_kp & ~kp_stop & ~fault_active) & (kp_run | keypad_run);

  // terminal hold-off; a clear event beats the release path
  wire logic next_term_wait =
    fault_clear ? ~fault_clear_autostart :
    first_cycle ? ~power_up_autostart :
    term_wait & term_req;

  // run outputs and hold-off state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_idle;
      run_cmd <= 1'b0;
      dir_reverse <= 1'b0;
      step_index <= 3'h0;
      freq_target <= 16'h0000;
      keypad_run <= 1'b0;
      term_wait <= 1'b1;
      first_cycle <= 1'b1;
    end else begin
      state <= next_state;
      run_cmd <= next_state == st_run;
      dir_reverse <= next_dir;
      // target is registered on the same edge as the step index
      step_index <= next_step;
      freq_target <= next_freq;
      keypad_run <= next_kp_run;
      term_wait <= next_term_wait;
      first_cycle <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  step_zero_a: assert property (!go |=> step_index == 3'h0)
    else $error("step index not zero without run");
  step_decode_a: assert property (go |=> step_index == $past(step_bits))
    else $error("step index does not follow select bits");
  step_freq_a: assert property ((go && step_bits != 3'h0 && !wr) |=>
    freq_target == step_freq[(step_index - 3'h1)*16 +: 16])
    else $error("step frequency not selected");
  key_stop_a: assert property ((mode_kp && kp_stop) |=> !keypad_run ##1 !run_cmd)
    else $error("stop key did not stop keypad run");
  remote_mask_a: assert property ((remote_keypad_present && run_key && !remote_run_key
    && !keypad_run) |=> !keypad_run)
    else $error("built-in key acted with remote keypad");
  both_equal_a: assert property ((mode_t1 && fwd_t == rev_t) |=> !run_cmd)
    else $error("equal run terminals did not stop");
  bip_invert_a: assert property ((state == st_idle && go && bip_neg) |=>
    run_cmd && dir_reverse == !$past(raw_rev))
    else $error("negative bipolar input did not invert");
  flip_stop_a: assert property ((state == st_run && go && want_rev != dir_reverse) |=>
    !run_cmd ##1 (state != st_run || dir_reverse == $past(want_rev)))
    else $error("direction flip did not pass through stop");
  inhibit_a: assert property ((run_cmd && direction_inhibit_sel == `RSC_INH_FWD)
    |-> ##1 (!run_cmd || dir_reverse || $past(ctrl) != ctrl))
    else $error("forward run while forward inhibited");
  hold_off_a: assert property ((term_mode && term_wait) |=> !run_cmd)
    else $error("held terminal started without autostart");
  clear_wait_a: assert property ((fault_clear && !fault_clear_autostart) |=> term_wait)
    else $error("fault clear did not arm hold-off");
  clear_hold_a: assert property ((term_mode && fault_clear && !fault_clear_autostart)
    |=> !run_cmd)
    else $error("run started in the fault clear cycle");
endmodule

// [tb_top.sv]
// self-checking bench for the run/step selector
`timescale 1ns/1ps
module tb_top;
  import rsc_pkg::*;
  logic clk_sys, rst_n, cyc, stb, we;
  logic [7:0] adr, term_in;
  logic [3:0] sel;
  logic [31:0] dat, wb_dat_o, q;
  logic wb_ack_o, run_key, stop_key, rem, rem_run, rem_stop;
  logic signed [11:0] bip;
  logic [15:0] aref;
  logic flt, fclr, mstop, run_cmd, dir_reverse;
  rsc_step_t step_index;
  rsc_freq_t freq_target;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [15:0] fexp [8] = '{16'h1234, 16'h03E8, 16'h07D0, 16'h0BB8, 16'h0BB8, 16'h09C4,
                            16'h07D0, 16'h05DC};
  rsc_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .term_in(term_in), .run_key(run_key), .stop_reset_key(stop_key),
    .remote_keypad_present(rem), .remote_run_key(rem_run), .remote_stop_key(rem_stop),
    .bipolar_voltage_input(bip), .analog_freq_ref(aref), .fault_active(flt),
    .fault_clear(fclr), .motor_stopped(mstop), .run_cmd(run_cmd),
    .dir_reverse(dir_reverse), .step_index(step_index), .freq_target(freq_target));
  rsc_partner i_partner (.clk_sys(clk_sys), .rst_n(rst_n), .run_cmd(run_cmd),
    .term_in(term_in), .run_key(run_key), .stop_reset_key(stop_key),
    .remote_keypad_present(rem), .remote_run_key(rem_run), .remote_stop_key(rem_stop),
    .bipolar_voltage_input(bip), .analog_freq_ref(aref), .fault_active(flt),
    .fault_clear(fclr), .motor_stopped(mstop));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, generous against the few hundred cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic cycle; no answer latency assumed, only the bound cuts a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hF};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n == 20) chk("wb_ack_o", wb_ack_o, 1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk("wb_dat_o", q, e);
  endtask
  task automatic go(input logic [7:0] t, input logic [4:0] k = 0, input logic n = 0);
    i_partner.drive(t, k, n, 1'b0);
  endtask
  // outputs settle one cycle after inputs, two through the keypad latch; reversal may take longer
  task automatic exp_out(input logic r, input logic d = 0);
    int n;
    repeat (3) @(posedge clk_sys);
    n = 0;
    while ((run_cmd !== r || (r && dir_reverse !== d)) && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    chk("run_cmd", run_cmd, r);
    if (r) chk("dir_reverse", dir_reverse, d);
  endtask
  task automatic idle();
    go(0);
    repeat (10) @(posedge clk_sys);
  endtask
  initial begin
    {cyc, stb, we, adr, dat, sel} = '0;
    rst_n = 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(8'h00, 32'h1); rd(8'h04, 32'h03020100); rd(8'h08, 32'h07060504);
    rd(8'h20, 32'h3E8); rd(8'h2C, 32'hBB8); rd(8'h38, 32'h5DC); rd(8'hFC, 0);
    rd(8'h10, 32'h00030100);
    wb(1, 8'h10, 32'h00030000); rd(8'h10, 32'h00030100);
    wb(1, 8'h10, 32'hFFFF01FF); rd(8'h10, 32'h00070101);
    // terminal pair decoding
    wb(1, 8'h00, 1);
    go(1); exp_out(1, 0);
    go(3); exp_out(0);
    go(2); exp_out(1, 1);
    idle(); exp_out(0);
    // step select walk, run held throughout
    wb(1, 8'h0C, 32'h1234);
    go(1); exp_out(1, 0);
    for (int i = 0; i < 8; i++) begin
      go({i[2:0], 5'h01});
      repeat (2) @(posedge clk_sys);
      chk("step_index", step_index, i);
      chk("freq_target", freq_target, fexp[i]);
      chk("run_cmd", run_cmd, 1);
    end
    wb(1, 8'h08, 32'h07060405); go(8'h11); repeat (2) @(posedge clk_sys);
    chk("freq_target", freq_target, fexp[1]);
    wb(1, 8'h08, 32'h07060504); idle();
    // run plus direction terminals
    wb(1, 8'h00, 2);
    go(1); exp_out(1, 0);
    rd(8'h18, 32'h12340101);
    go(3); exp_out(0); exp_out(1, 1);
    go(2); exp_out(0);
    idle();
    // direction inhibit both ways, the first one landing mid-run
    wb(1, 8'h00, 1);
    go(1);
    exp_out(1, 0);
    wb(1, 8'h00, 32'h101);
    exp_out(0);
    go(2); exp_out(1, 1); idle();
    wb(1, 8'h00, 32'h201);
    go(2); exp_out(0); go(1); exp_out(1, 0); idle();
    // keypad: latched run, stop wins, direction bit, remote masks built-in
    wb(1, 8'h00, 0);
    go(0, 5'h02); go(0); exp_out(1, 0);
    go(0, 5'h03); go(0); exp_out(0);
    wb(1, 8'h00, 32'h1000);
    go(0, 5'h02); go(0); exp_out(1, 1); go(0, 5'h01); idle();
    go(0, 5'h12); exp_out(0);
    go(0, 5'h18); exp_out(1, 1); go(0, 5'h14); exp_out(0); idle();
    // serial master commands, terminals ignored
    wb(1, 8'h00, 3);
    go(1); exp_out(0);
    wb(1, 8'h14, 1); exp_out(1, 0); wb(1, 8'h14, 3); exp_out(0);
    wb(1, 8'h14, 2); exp_out(1, 1); wb(1, 8'h14, 0); idle();
    // bipolar polarity flips direction, checked with the terminal run source
    wb(1, 8'h00, 32'h21);
    go(1); exp_out(1, 0);
    chk("freq_target", freq_target, 16'h0ABC);
    go(1, 0, 1); exp_out(0); exp_out(1, 1); idle();
    go(2, 0, 1); exp_out(1, 0); idle();
    // restart after fault clear, with and without the option
    wb(1, 8'h00, 32'h20001);
    go(1); exp_out(1, 0); i_partner.drive(1, 0, 0, 1); exp_out(0);
    i_partner.end_fault(); exp_out(1, 0);
    wb(1, 8'h00, 1);
    i_partner.drive(1, 0, 0, 1); exp_out(0); i_partner.end_fault();
    @(posedge clk_sys);
    chk("run_cmd", run_cmd, 0);
    exp_out(0);
    idle(); go(1); exp_out(1, 0);
    // second reset with the terminal held and power-up start left off
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    wb(1, 8'h00, 1); exp_out(0);
    idle(); go(1); exp_out(1, 0);
    idle();
    print_verdict();
  end
endmodule
